//--- e1_common_control_pkg.sv
// constants and types shared by the e1 framer common control logic
package e1_common_control_pkg;

  // register offsets on the parallel port
  localparam logic [7:0] SIG_BACKPLANE_CFG_ADDR = 8'h1B;
  localparam logic [7:0] LOOPBACK_MONITOR_CFG_ADDR = 8'hA8;

  // reset values
  localparam logic [7:0] SIG_BACKPLANE_CFG_RESET = 8'h00;
  localparam logic [7:0] LOOPBACK_MONITOR_CFG_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

  // writable bit masks; unassigned positions always read zero
  localparam logic [7:0] SIG_BACKPLANE_CFG_MASK = 8'hEF;
  localparam logic [7:0] LOOPBACK_MONITOR_CFG_MASK = 8'h9F;

  // signaling_backplane_config fields
  localparam int TX_ELASTIC_STORE_ENABLE_BIT = 7;
  localparam int TX_BLOCKING_FUNCTION_SELECT_BIT = 6;
  localparam int TX_IDLE_FUNCTION_SELECT_BIT = 5;
  localparam int RX_SIGNALING_REINSERT_ENABLE_BIT = 3;
  localparam int TX_HW_SIGNALING_INSERT_ENABLE_BIT = 2;
  localparam int TX_BACKPLANE_CLOCK_SELECT_BIT = 1;
  localparam int RX_CARRIER_LOSS_ALT_CRITERIA_BIT = 0;

  // loopback_monitor_config fields
  localparam int REMOTE_LOOPBACK_ENABLE_BIT = 7;
  localparam int TX_MONITOR_CHANNEL_SEL_MSB = 4;
  localparam int TX_MONITOR_CHANNEL_SEL_LSB = 0;

  // carrier loss zero-run thresholds
  localparam logic [11:0] CARRIER_LOSS_ZEROS = 12'h0FF;
  localparam logic [11:0] CARRIER_LOSS_ALT_ZEROS = 12'h800;

  // timing
  localparam int CLOCK_MHZ = 250;
  localparam int CYCLES_PER_MS = CLOCK_MHZ * 1000;
  localparam int MF_SEARCH_ALARM_MS = 128;
  localparam int MF_SEARCH_LOST_MS = 400;
  localparam int MF_TIMER_WIDTH = 27;

  // crc4 multiframe search progress
  typedef enum logic [1:0] {
    MF_IDLE,
    MF_SEARCH,
    MF_LATE,
    MF_LOST
  } mf_search_type;

  // complete register state of the block
  typedef struct packed {
    logic [7:0] sig_cfg;
    logic [7:0] lb_cfg;
    logic [7:0] rd_data;
    logic [7:0] monitor;
    logic [11:0] zero_count;
    logic carrier_loss;
    mf_search_type mf_state;
    logic [MF_TIMER_WIDTH-1:0] mf_timer;
    logic ais_send;
    logic rai_send;
  } state_type;

endpackage : e1_common_control_pkg

//--- e1_framer_common_control.sv
// common control registers and automatic alarm generation of one e1 framer
`timescale 1ns/1ps

module e1_framer_common_control #(
  parameter int unsigned MF_ALARM_CYCLES =
    e1_common_control_pkg::MF_SEARCH_ALARM_MS * e1_common_control_pkg::CYCLES_PER_MS,
  parameter int unsigned MF_LOST_CYCLES =
    e1_common_control_pkg::MF_SEARCH_LOST_MS * e1_common_control_pkg::CYCLES_PER_MS
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic wr_b,
  input wire logic rd_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic auto_ais_enable,
  input wire logic auto_remote_alarm_enable,
  input wire logic crc4_enable,
  input wire logic rx_frame_sync_loss,
  input wire logic rx_ais_detect,
  input wire logic rx_mf_sync_found,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic tx_channel_strobe,
  input wire logic [4:0] tx_channel_index,
  input wire logic [7:0] tx_channel_data,
  output logic rx_carrier_loss,
  output logic tx_ais_send,
  output logic tx_remote_alarm_send,
  output logic tx_elastic_store_enable,
  output logic tx_blocking_function_select,
  output logic tx_idle_function_select,
  output logic rx_signaling_reinsert_enable,
  output logic tx_hw_signaling_insert_enable,
  output logic tx_backplane_clock_select,
  output logic rx_carrier_loss_alt_criteria,
  output logic remote_loopback_enable,
  output logic [4:0] tx_monitor_channel_sel,
  output logic [7:0] tx_channel_monitor_reg
);

  // search limits cut to the timer width on purpose
  localparam int TW = e1_common_control_pkg::MF_TIMER_WIDTH;
  localparam logic [TW-1:0] MF_ALARM_COUNT = MF_ALARM_CYCLES[TW-1:0];
  localparam logic [TW-1:0] MF_LOST_COUNT = MF_LOST_CYCLES[TW-1:0];

  e1_common_control_pkg::state_type state_reg;
  e1_common_control_pkg::state_type state_next;

  logic wr_access;
  logic rd_access;
  logic rx_fault;
  logic [11:0] zero_limit;

  ////////////////////////////////////////////////////////////////////////////
  // parallel port strobes
  assign wr_access = !cs_b && !wr_b;
  assign rd_access = !cs_b && !rd_b;

  // receive conditions common to both automatic alarms
  assign rx_fault = rx_frame_sync_loss || rx_ais_detect || state_reg.carrier_loss;

  // zero run that declares carrier loss
  assign zero_limit = state_reg.sig_cfg[e1_common_control_pkg::RX_CARRIER_LOSS_ALT_CRITERIA_BIT]
    ? e1_common_control_pkg::CARRIER_LOSS_ALT_ZEROS
    : e1_common_control_pkg::CARRIER_LOSS_ZEROS;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    state_next = state_reg;

    // register writes, unassigned bits forced to zero
    if (wr_access) begin
      if (addr == e1_common_control_pkg::SIG_BACKPLANE_CFG_ADDR) begin
        state_next.sig_cfg = wr_data & e1_common_control_pkg::SIG_BACKPLANE_CFG_MASK;
      end
      if (addr == e1_common_control_pkg::LOOPBACK_MONITOR_CFG_ADDR) begin
        state_next.lb_cfg = wr_data & e1_common_control_pkg::LOOPBACK_MONITOR_CFG_MASK;
      end
    end

    // register reads; unmapped addresses return zero
    if (rd_access) begin
      if (addr == e1_common_control_pkg::SIG_BACKPLANE_CFG_ADDR) begin
        state_next.rd_data = state_reg.sig_cfg;
      end else if (addr == e1_common_control_pkg::LOOPBACK_MONITOR_CFG_ADDR) begin
        state_next.rd_data = state_reg.lb_cfg;
      end else begin
        state_next.rd_data = e1_common_control_pkg::READ_IDLE_VALUE;
      end
    end

    // transmit channel monitor capture
    if (tx_channel_strobe && tx_channel_index == state_reg.lb_cfg[
        e1_common_control_pkg::TX_MONITOR_CHANNEL_SEL_MSB:
        e1_common_control_pkg::TX_MONITOR_CHANNEL_SEL_LSB]) begin
      state_next.monitor = tx_channel_data;
    end

    // consecutive zero counter for carrier loss
    if (rx_bit_valid) begin
      if (rx_bit) begin
        state_next.zero_count = '0;
        state_next.carrier_loss = 1'b0;
      end else if (state_reg.zero_count < zero_limit) begin
        state_next.zero_count = state_reg.zero_count + 12'h001;
        state_next.carrier_loss = (state_reg.zero_count + 12'h001) >= zero_limit;
      end else begin
        state_next.carrier_loss = 1'b1;
      end
    end

    // crc4 multiframe search timer, started by frame alignment
    unique case (state_reg.mf_state)
      e1_common_control_pkg::MF_IDLE: begin
        state_next.mf_timer = '0;
        if (crc4_enable && !rx_frame_sync_loss && !rx_mf_sync_found) begin
          state_next.mf_state = e1_common_control_pkg::MF_SEARCH;
        end
      end
      e1_common_control_pkg::MF_SEARCH, e1_common_control_pkg::MF_LATE: begin
        state_next.mf_timer = state_reg.mf_timer + 27'h0000001;
        if (!crc4_enable || rx_frame_sync_loss || rx_mf_sync_found) begin
          state_next.mf_state = e1_common_control_pkg::MF_IDLE;
        end else if (state_reg.mf_timer + 27'h0000001 >= MF_LOST_COUNT) begin
          state_next.mf_state = e1_common_control_pkg::MF_LOST;
        end else if (state_reg.mf_timer + 27'h0000001 >= MF_ALARM_COUNT) begin
          state_next.mf_state = e1_common_control_pkg::MF_LATE;
        end
      end
      e1_common_control_pkg::MF_LOST: begin
        // remote alarm held until multiframe found or crc4 off
        if (!crc4_enable || rx_mf_sync_found) begin
          state_next.mf_state = e1_common_control_pkg::MF_IDLE;
        end
      end
    endcase

    // automatic alarms; ais wins if both enables are set illegally
    state_next.ais_send = auto_ais_enable && rx_fault;
    state_next.rai_send = auto_remote_alarm_enable && !auto_ais_enable &&
      (rx_fault || state_reg.mf_state != e1_common_control_pkg::MF_IDLE &&
       state_reg.mf_state != e1_common_control_pkg::MF_SEARCH);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg.sig_cfg <= e1_common_control_pkg::SIG_BACKPLANE_CFG_RESET;
      state_reg.lb_cfg <= e1_common_control_pkg::LOOPBACK_MONITOR_CFG_RESET;
      state_reg.rd_data <= e1_common_control_pkg::READ_IDLE_VALUE;
      state_reg.monitor <= 8'h00;
      state_reg.zero_count <= 12'h000;
      state_reg.carrier_loss <= 1'b0;
      state_reg.mf_state <= e1_common_control_pkg::MF_IDLE;
      state_reg.mf_timer <= 27'h0000000;
      state_reg.ais_send <= 1'b0;
      state_reg.rai_send <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign rd_data = state_reg.rd_data;
  assign rx_carrier_loss = state_reg.carrier_loss;
  assign tx_ais_send = state_reg.ais_send;
  assign tx_remote_alarm_send = state_reg.rai_send;
  assign tx_channel_monitor_reg = state_reg.monitor;

  // configuration bits steering the datapaths
  assign tx_elastic_store_enable =
    state_reg.sig_cfg[e1_common_control_pkg::TX_ELASTIC_STORE_ENABLE_BIT];
  assign tx_blocking_function_select =
    state_reg.sig_cfg[e1_common_control_pkg::TX_BLOCKING_FUNCTION_SELECT_BIT];
  assign tx_idle_function_select =
    state_reg.sig_cfg[e1_common_control_pkg::TX_IDLE_FUNCTION_SELECT_BIT];
  assign rx_signaling_reinsert_enable =
    state_reg.sig_cfg[e1_common_control_pkg::RX_SIGNALING_REINSERT_ENABLE_BIT];
  assign tx_hw_signaling_insert_enable =
    state_reg.sig_cfg[e1_common_control_pkg::TX_HW_SIGNALING_INSERT_ENABLE_BIT];
  assign tx_backplane_clock_select =
    state_reg.sig_cfg[e1_common_control_pkg::TX_BACKPLANE_CLOCK_SELECT_BIT];
  assign rx_carrier_loss_alt_criteria =
    state_reg.sig_cfg[e1_common_control_pkg::RX_CARRIER_LOSS_ALT_CRITERIA_BIT];
  assign remote_loopback_enable =
    state_reg.lb_cfg[e1_common_control_pkg::REMOTE_LOOPBACK_ENABLE_BIT];
  assign tx_monitor_channel_sel = state_reg.lb_cfg[
    e1_common_control_pkg::TX_MONITOR_CHANNEL_SEL_MSB:
    e1_common_control_pkg::TX_MONITOR_CHANNEL_SEL_LSB];

endmodule : e1_framer_common_control

//--- e1_common_control_assertions.sv
// concurrent checks on the e1 framer common control ports
`timescale 1ns/1ps

module e1_common_control_checker (
  input wire logic mclk, rst_b, cs_b, wr_b, rd_b, rx_bit_valid, rx_bit,
  input wire logic [7:0] addr, wr_data, rd_data, tx_channel_data, tx_channel_monitor_reg,
  input wire logic auto_ais_enable, auto_remote_alarm_enable, rx_frame_sync_loss,
  input wire logic rx_ais_detect, tx_channel_strobe, rx_carrier_loss, tx_ais_send,
  input wire logic tx_remote_alarm_send, remote_loopback_enable,
  input wire logic [4:0] tx_channel_index, tx_monitor_channel_sel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // receive conditions common to both automatic alarms
  logic cause;
  assign cause = rx_frame_sync_loss | rx_ais_detect | rx_carrier_loss;

  ////////////////////////////////////////////////////////////////////////////////
  a_ais_on_cause: assert property (auto_ais_enable && cause |=> tx_ais_send)
    else $error("ais not sent on alarm cause");
  a_ais_off_disabled: assert property (!auto_ais_enable |=> !tx_ais_send)
    else $error("ais sent while disabled");
  a_rai_ais_exclusive: assert property (auto_ais_enable |=> !tx_remote_alarm_send)
    else $error("remote alarm with ais enabled");
  a_rai_on_cause: assert property (auto_remote_alarm_enable && !auto_ais_enable && cause
    |=> tx_remote_alarm_send) else $error("remote alarm not sent on cause");
  a_carrier_clears_one: assert property (rx_bit_valid && rx_bit |=> !rx_carrier_loss)
    else $error("carrier loss kept after a one");
  a_carrier_needs_bit: assert property (
    !rx_bit_valid && !rx_carrier_loss |=> !rx_carrier_loss)
    else $error("carrier loss without a valid bit");
  a_monitor_capture: assert property (
    tx_channel_strobe && tx_channel_index == tx_monitor_channel_sel
    |=> tx_channel_monitor_reg == $past(tx_channel_data)) else $error("monitor byte not captured");
  a_loopback_write: assert property (!cs_b && !wr_b && addr == 8'hA8
    |=> {remote_loopback_enable, 2'b00, tx_monitor_channel_sel} == ($past(wr_data) & 8'h9F))
    else $error("loopback config write lost");
  a_unmapped_read: assert property (!cs_b && !rd_b && addr != 8'h1B && addr != 8'hA8
    |=> rd_data == 8'h00) else $error("unmapped read not zero");

  // main scenarios reached
  c_carrier: cover property ($rose(rx_carrier_loss));
  c_rai: cover property ($rose(tx_remote_alarm_send));
  c_monitor: cover property (tx_channel_strobe && tx_channel_index == tx_monitor_channel_sel);
endmodule : e1_common_control_checker

//--- tb.sv
// self-checking bench for the e1 framer common control block
`timescale 1ns/1ps

module tb;
  logic mclk = 0, rst_b = 0, cs_b = 1, wr_b = 1, rd_b = 1, rx_bit_valid = 0, rx_bit = 0;
  logic auto_ais_enable = 0, auto_remote_alarm_enable = 0, crc4_enable = 0;
  logic rx_frame_sync_loss = 0, rx_ais_detect = 0, rx_mf_sync_found = 0, tx_channel_strobe = 0;
  logic [7:0] addr = 8'h00, wr_data = 8'h00, tx_channel_data = 8'h00;
  logic [4:0] tx_channel_index = 5'h00, tx_monitor_channel_sel;
  logic [7:0] rd_data, tx_channel_monitor_reg, sig_seen;
  logic rx_carrier_loss, tx_ais_send, tx_remote_alarm_send, remote_loopback_enable;
  logic tx_elastic_store_enable, tx_blocking_function_select, tx_idle_function_select;
  logic rx_signaling_reinsert_enable, tx_hw_signaling_insert_enable;
  logic tx_backplane_clock_select, rx_carrier_loss_alt_criteria;
  int mismatches = 0, cmp_count = 0;
  localparam int ALARM = 20;
  localparam int LOST = 60;

  e1_framer_common_control #(.MF_ALARM_CYCLES(ALARM), .MF_LOST_CYCLES(LOST))
    e1_framer_common_control_inst (
    .mclk(mclk), .rst_b(rst_b), .cs_b(cs_b), .wr_b(wr_b), .rd_b(rd_b), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .auto_ais_enable(auto_ais_enable),
    .auto_remote_alarm_enable(auto_remote_alarm_enable), .crc4_enable(crc4_enable),
    .rx_frame_sync_loss(rx_frame_sync_loss), .rx_ais_detect(rx_ais_detect),
    .rx_mf_sync_found(rx_mf_sync_found), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .tx_channel_strobe(tx_channel_strobe), .tx_channel_index(tx_channel_index),
    .tx_channel_data(tx_channel_data), .rx_carrier_loss(rx_carrier_loss),
    .tx_ais_send(tx_ais_send), .tx_remote_alarm_send(tx_remote_alarm_send),
    .tx_elastic_store_enable(tx_elastic_store_enable),
    .tx_blocking_function_select(tx_blocking_function_select),
    .tx_idle_function_select(tx_idle_function_select),
    .rx_signaling_reinsert_enable(rx_signaling_reinsert_enable),
    .tx_hw_signaling_insert_enable(tx_hw_signaling_insert_enable),
    .tx_backplane_clock_select(tx_backplane_clock_select),
    .rx_carrier_loss_alt_criteria(rx_carrier_loss_alt_criteria),
    .remote_loopback_enable(remote_loopback_enable),
    .tx_monitor_channel_sel(tx_monitor_channel_sel),
    .tx_channel_monitor_reg(tx_channel_monitor_reg)
  );
  assign sig_seen = {tx_elastic_store_enable, tx_blocking_function_select,
    tx_idle_function_select, 1'b0, rx_signaling_reinsert_enable,
    tx_hw_signaling_insert_enable, tx_backplane_clock_select, rx_carrier_loss_alt_criteria};

  // 250 MHz clock
  always #2 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {cs_b, wr_b, addr, wr_data} = {2'b00, a, d};
    cyc(1);
    {cs_b, wr_b} = 2'b11;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    {cs_b, rd_b, addr} = {2'b00, a};
    cyc(1);
    {cs_b, rd_b} = 2'b11;
    cyc(1);
    chk("rd_data", exp, rd_data);
  endtask : rd
  task automatic bits(input logic b, input int n);
    repeat (n) begin
      {rx_bit_valid, rx_bit} = {1'b1, b};
      cyc(1);
      rx_bit_valid = 0;
      cyc(1);
    end
  endtask : bits
  task automatic strobe(input logic [4:0] i, input logic [7:0] d);
    {tx_channel_strobe, tx_channel_index, tx_channel_data} = {1'b1, i, d};
    cyc(1);
    tx_channel_strobe = 0;
    cyc(1);
  endtask : strobe

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(8'h1B, 8'h00);
    rd(8'hA8, 8'h00);
    wr(8'h1B, 8'hEF);
    chk("sig cfg", 8'hEF, sig_seen);
    rd(8'h1B, 8'hEF);
    wr(8'hA8, 8'h9F);
    chk("lb cfg", 8'h9F, {remote_loopback_enable, 2'b00, tx_monitor_channel_sel});
    wr(8'h1C, 8'h00);
    rd(8'h1B, 8'hEF);
    rd(8'h1C, 8'h00);
    wr(8'h1B, 8'h4A);
    chk("sig cfg", 8'h4A, sig_seen);
    wr(8'h1B, 8'h21);
    chk("sig cfg", 8'h21, sig_seen);
  endtask : t_regs
  task automatic t_monitor();
    wr(8'hA8, 8'h05);
    strobe(5'h04, 8'h11);
    strobe(5'h05, 8'hA5);
    strobe(5'h06, 8'h77);
    chk("monitor", 8'hA5, tx_channel_monitor_reg);
    wr(8'hA8, 8'h1F);
    strobe(5'h1F, 8'h3C);
    chk("monitor", 8'h3C, tx_channel_monitor_reg);
  endtask : t_monitor
  task automatic t_carrier(input logic alt, input int n);
    wr(8'h1B, {7'h00, alt});
    bits(1'b0, n - 1);
    chk("carrier", 8'h00, rx_carrier_loss);
    bits(1'b0, 1);
    chk("carrier", 8'h01, rx_carrier_loss);
    auto_ais_enable = 1;
    cyc(2);
    chk("ais", 8'h01, tx_ais_send);
    auto_ais_enable = 0;
    bits(1'b1, 1);
    chk("carrier", 8'h00, rx_carrier_loss);
  endtask : t_carrier
  task automatic t_alarms();
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 3; c++) begin
        {auto_remote_alarm_enable, auto_ais_enable} = m[1:0];
        {rx_ais_detect, rx_frame_sync_loss} = c[1:0];
        cyc(2);
        chk("ais", {7'h00, c != 0 && m[0]}, tx_ais_send);
        chk("rai", {7'h00, c != 0 && m == 2}, tx_remote_alarm_send);
      end
    end
    {auto_remote_alarm_enable, auto_ais_enable, rx_ais_detect, rx_frame_sync_loss} = 4'h0;
  endtask : t_alarms
  task automatic t_multiframe();
    {auto_remote_alarm_enable, crc4_enable} = 2'b11;
    cyc(ALARM + 1);
    chk("rai", 8'h00, tx_remote_alarm_send);
    cyc(1);
    repeat (LOST) begin
      chk("rai", 8'h01, tx_remote_alarm_send);
      cyc(1);
    end
    // a short frame sync loss must not end the latched alarm
    rx_frame_sync_loss = 1;
    cyc(1);
    rx_frame_sync_loss = 0;
    cyc(3);
    chk("rai", 8'h01, tx_remote_alarm_send);
    rx_mf_sync_found = 1;
    cyc(3);
    chk("rai", 8'h00, tx_remote_alarm_send);
    {auto_remote_alarm_enable, crc4_enable, rx_mf_sync_found} = 3'b000;
  endtask : t_multiframe

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    cyc(4);
    rst_b = 1;
    cyc(1);
    t_regs();
    t_monitor();
    t_carrier(1'b0, 255);
    t_carrier(1'b1, 2048);
    t_alarms();
    t_multiframe();
    print_verdict();
  end

  // watchdog against a hang
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
endmodule : tb

bind e1_framer_common_control e1_common_control_checker e1_common_control_checker_inst (
  .mclk(mclk), .rst_b(rst_b), .cs_b(cs_b), .wr_b(wr_b), .rd_b(rd_b),
  .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .addr(addr), .wr_data(wr_data),
  .rd_data(rd_data), .tx_channel_data(tx_channel_data),
  .tx_channel_monitor_reg(tx_channel_monitor_reg), .auto_ais_enable(auto_ais_enable),
  .auto_remote_alarm_enable(auto_remote_alarm_enable),
  .rx_frame_sync_loss(rx_frame_sync_loss), .rx_ais_detect(rx_ais_detect),
  .tx_channel_strobe(tx_channel_strobe), .rx_carrier_loss(rx_carrier_loss),
  .tx_ais_send(tx_ais_send), .tx_remote_alarm_send(tx_remote_alarm_send),
  .remote_loopback_enable(remote_loopback_enable), .tx_channel_index(tx_channel_index),
  .tx_monitor_channel_sel(tx_monitor_channel_sel)
);
